// [verilog/rpwm_pkg.sv]
// Register map, field positions, reset values and timing figures for
// channel 0 of the reset-synchronous PWM timer.
// Assumes a 25 MHz single-clock system and an AXI4-Lite register bus.
package rpwm_pkg;

  localparam int CLK_PERIOD_NS = 40;
  // Example PWM period and change point
  localparam int PWM_PERIOD_NS = 200000;
  localparam int PWM_CHANGE_NS = 50000;
  localparam int PWM_PERIOD_CYC = PWM_PERIOD_NS / CLK_PERIOD_NS;
  localparam int PWM_CHANGE_CYC = PWM_CHANGE_NS / CLK_PERIOD_NS;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_IER = 8'h04;
  localparam logic [7:0] OFS_GRA0 = 8'h08;
  localparam logic [7:0] OFS_GRB0 = 8'h0C;
  localparam logic [7:0] OFS_GRC0 = 8'h10;
  localparam logic [7:0] OFS_GRD0 = 8'h14;
  localparam logic [7:0] OFS_GRA1 = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;
  localparam logic [7:0] OFS_OUTDIS = 8'h20;
  localparam logic [7:0] OFS_RUN = 8'h24;
  localparam logic [7:0] OFS_COUNT = 8'h28;

  localparam int CLR_SEL_HI = 7;
  localparam int CLR_SEL_LO = 5;
  localparam int SRC_SEL_HI = 2;
  localparam int SRC_SEL_LO = 0;
  localparam int IER_WRAP_BIT = 4;
  localparam int RUN_START_BIT = 0;
  localparam int RUN_BUFFER_BIT = 1;
  localparam int PIN_A0_BIT = 0;
  localparam int PIN_B0_BIT = 1;

  localparam logic [2:0] CLR_FREE = 3'h0;
  localparam logic [2:0] CLR_ON_A = 3'h1;
  localparam logic [2:0] CLR_ON_B = 3'h2;
  localparam logic [2:0] CLR_SYNC = 3'h3;
  localparam logic [2:0] CLR_ON_C = 3'h5;
  localparam logic [2:0] CLR_ON_D = 3'h6;

  localparam logic [2:0] SRC_CLK = 3'h0;
  localparam logic [2:0] SRC_DIV2 = 3'h1;
  localparam logic [2:0] SRC_DIV4 = 3'h2;
  localparam logic [2:0] SRC_DIV8 = 3'h3;
  localparam logic [2:0] SRC_DIV32 = 3'h4;
  localparam logic [2:0] SRC_EXT = 3'h5;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] IER_RESET = 8'h00;
  localparam logic [7:0] OUTDIS_RESET = 8'hFF;
  localparam logic [15:0] GR_RESET = 16'hFFFF;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// [verilog/rpwm_prescale.sv]
// Count-source selector: one-cycle tick at the chosen rate.
// Assumes extRise is already synchronised to clk.
`timescale 1ns/1ps
module rpwm_prescale (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [2:0] srcSel,
  input wire logic extRise,
  output logic tick
);

  typedef struct packed {
    logic [4:0] div;
    logic tick;
  } rpwm_pre_t;

  rpwm_pre_t s_q;
  rpwm_pre_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.div = s_q.div + 5'h01;
    unique case (srcSel)
      rpwm_pkg::SRC_CLK: s_d.tick = 1'b1;
      rpwm_pkg::SRC_DIV2: s_d.tick = s_q.div[0];
      rpwm_pkg::SRC_DIV4: s_d.tick = &s_q.div[1:0];
      rpwm_pkg::SRC_DIV8: s_d.tick = &s_q.div[2:0];
      rpwm_pkg::SRC_DIV32: s_d.tick = &s_q.div[4:0];
      rpwm_pkg::SRC_EXT: s_d.tick = extRise;
      // Reserved codes stop the count
      default: s_d.tick = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;

endmodule

// [verilog/rpwm_channel0.sv]
// Channel 0 of the reset-synchronous PWM timer with AXI4-Lite registers.
// Assumes otherClear is a same-clock pulse from channel 1's clear logic.
`timescale 1ns/1ps
module rpwm_channel0 #(
  parameter int PeriodCycles = rpwm_pkg::PWM_PERIOD_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic externalCountInput,
  input wire logic otherClear,
  output logic clearOut,
  output logic pwmPinA0Out,
  output logic pwmPinA0Oe,
  output logic pwmPinB0Out,
  output logic pwmPinB0Oe,
  output logic irq
);

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] ier;
    logic [15:0] gra0;
    logic [15:0] grb0;
    logic [15:0] grc0;
    logic [15:0] grd0;
    logic [15:0] gra1;
    logic [4:0] flags;
    logic [7:0] outDis;
    logic [1:0] run;
    logic [15:0] cnt;
    logic pwm;
    logic pwmN;
    logic oeA;
    logic oeB;
    logic ext1;
    logic ext2;
    logic ext3;
    logic clearOut;
    logic irq;
    logic awHeld;
    logic [7:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rpwm_state_t;

  localparam logic [15:0] PeriodReset = 16'(PeriodCycles - 1);
  localparam logic [15:0] ChangeReset = 16'(rpwm_pkg::PWM_CHANGE_CYC);

  rpwm_state_t s_q;
  rpwm_state_t s_d;
  logic tick;

  function automatic logic isMapped(input logic [7:0] a);
    unique case (a)
      rpwm_pkg::OFS_CTRL, rpwm_pkg::OFS_IER, rpwm_pkg::OFS_GRA0,
      rpwm_pkg::OFS_GRB0, rpwm_pkg::OFS_GRC0, rpwm_pkg::OFS_GRD0,
      rpwm_pkg::OFS_GRA1, rpwm_pkg::OFS_STATUS, rpwm_pkg::OFS_OUTDIS,
      rpwm_pkg::OFS_RUN, rpwm_pkg::OFS_COUNT: isMapped = 1'b1;
      default: isMapped = 1'b0;
    endcase
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old,
      input logic [31:0] d, input logic [3:0] strb);
    merge16 = {strb[1] ? d[15:8] : old[15:8], strb[0] ? d[7:0] : old[7:0]};
  endfunction

  function automatic logic [31:0] readReg(input rpwm_state_t s,
      input logic [7:0] a);
    unique case (a)
      rpwm_pkg::OFS_CTRL: readReg = {24'h00_0000, s.ctrl};
      // Unassigned enable bits 7..5 read zero
      rpwm_pkg::OFS_IER: readReg = {27'h000_0000, s.ier[4:0]};
      rpwm_pkg::OFS_GRA0: readReg = {16'h0000, s.gra0};
      rpwm_pkg::OFS_GRB0: readReg = {16'h0000, s.grb0};
      rpwm_pkg::OFS_GRC0: readReg = {16'h0000, s.grc0};
      rpwm_pkg::OFS_GRD0: readReg = {16'h0000, s.grd0};
      rpwm_pkg::OFS_GRA1: readReg = {16'h0000, s.gra1};
      // Up-count only, so the underflow bit 5 never sets
      rpwm_pkg::OFS_STATUS: readReg = {27'h000_0000, s.flags};
      rpwm_pkg::OFS_OUTDIS: readReg = {24'h00_0000, s.outDis};
      rpwm_pkg::OFS_RUN: readReg = {30'h0000_0000, s.run};
      rpwm_pkg::OFS_COUNT: readReg = {16'h0000, s.cnt};
      default: readReg = 32'h0000_0000;
    endcase
  endfunction

  rpwm_prescale u_prescale (
    .clk(clk),
    .reset_n(reset_n),
    .srcSel(s_q.ctrl[rpwm_pkg::SRC_SEL_HI:rpwm_pkg::SRC_SEL_LO]),
    .extRise(s_q.ext2 & ~s_q.ext3),
    .tick(tick)
  );

  logic running;
  logic step;
  logic [3:0] match;
  logic clearNow;
  logic wrap;
  logic [4:0] w1c;
  logic doWrite;

  always_comb begin
    s_d = s_q;
    w1c = 5'h00;
    running = s_q.run[rpwm_pkg::RUN_START_BIT];
    step = running & tick;
    // Two-flop synchroniser, edge taken after the second stage
    s_d.ext1 = externalCountInput;
    s_d.ext2 = s_q.ext1;
    s_d.ext3 = s_q.ext2;

    // Register write, once address and data are both held
    // Address and data may land in either order
    doWrite = s_q.awHeld & s_q.wHeld & ~s_q.bvalid;
    if (doWrite) begin
      s_d.bvalid = 1'b1;
      s_d.awHeld = 1'b0;
      s_d.wHeld = 1'b0;
      s_d.bresp = isMapped(s_q.awAddr) ? rpwm_pkg::RESP_OKAY
                                       : rpwm_pkg::RESP_SLVERR;
      unique case (s_q.awAddr)
        rpwm_pkg::OFS_CTRL:
          if (s_q.wStrb[0]) s_d.ctrl = s_q.wData[7:0];
        rpwm_pkg::OFS_IER:
          if (s_q.wStrb[0]) s_d.ier = {3'h0, s_q.wData[4:0]};
        rpwm_pkg::OFS_GRA0:
          s_d.gra0 = merge16(s_q.gra0, s_q.wData, s_q.wStrb);
        rpwm_pkg::OFS_GRB0:
          s_d.grb0 = merge16(s_q.grb0, s_q.wData, s_q.wStrb);
        rpwm_pkg::OFS_GRC0:
          s_d.grc0 = merge16(s_q.grc0, s_q.wData, s_q.wStrb);
        rpwm_pkg::OFS_GRD0:
          s_d.grd0 = merge16(s_q.grd0, s_q.wData, s_q.wStrb);
        rpwm_pkg::OFS_GRA1:
          s_d.gra1 = merge16(s_q.gra1, s_q.wData, s_q.wStrb);
        rpwm_pkg::OFS_STATUS:
          if (s_q.wStrb[0]) w1c = s_q.wData[4:0];
        rpwm_pkg::OFS_OUTDIS:
          if (s_q.wStrb[0]) s_d.outDis = s_q.wData[7:0];
        rpwm_pkg::OFS_RUN:
          if (s_q.wStrb[0]) s_d.run = s_q.wData[1:0];
        default: ;
      endcase
    end
    if (s_q.bvalid && bready) begin
      s_d.bvalid = 1'b0;
    end
    if (awvalid && s_q.awready) begin
      s_d.awHeld = 1'b1;
      s_d.awAddr = awaddr;
    end
    if (wvalid && s_q.wready) begin
      s_d.wHeld = 1'b1;
      s_d.wData = wdata;
      s_d.wStrb = wstrb;
    end
    s_d.awready = ~s_d.awHeld & ~s_d.bvalid;
    s_d.wready = ~s_d.wHeld & ~s_d.bvalid;

    // Register read: data answered at the edge that takes the address
    if (s_q.rvalid && rready) begin
      s_d.rvalid = 1'b0;
    end
    if (arvalid && s_q.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = readReg(s_q, araddr);
      s_d.rresp = isMapped(araddr) ? rpwm_pkg::RESP_OKAY
                                   : rpwm_pkg::RESP_SLVERR;
    end
    s_d.arready = ~s_d.rvalid & ~(arvalid & s_q.arready);

    match = {s_q.cnt == s_q.grd0, s_q.cnt == s_q.grc0,
             s_q.cnt == s_q.grb0, s_q.cnt == s_q.gra0} & {4{step}};

    unique case (s_q.ctrl[rpwm_pkg::CLR_SEL_HI:rpwm_pkg::CLR_SEL_LO])
      rpwm_pkg::CLR_ON_A: clearNow = match[0];
      rpwm_pkg::CLR_ON_B: clearNow = match[1];
      rpwm_pkg::CLR_SYNC: clearNow = running & otherClear;
      rpwm_pkg::CLR_ON_C: clearNow = match[2];
      rpwm_pkg::CLR_ON_D: clearNow = match[3];
      // Free running; reserved codes behave the same
      default: clearNow = 1'b0;
    endcase

    // A clear at FFFF is a period end, not an overflow
    // Count one per source tick
    wrap = step & ~clearNow & (s_q.cnt == rpwm_pkg::COUNT_MAX);
    if (clearNow) begin
      s_d.cnt = 16'h0000;
    end else if (step) begin
      s_d.cnt = s_q.cnt + 16'h0001;
    end
    // Registered so channel 1 sees a clean pulse
    s_d.clearOut = clearNow;

    // Period reload from the buffer at period end
    if (s_q.run[rpwm_pkg::RUN_BUFFER_BIT] && clearNow && match[0]) begin
      s_d.gra0 = s_q.grc0;
    end

    if (clearNow) begin
      s_d.pwm = 1'b1;
    end else if (match[1]) begin
      s_d.pwm = 1'b0;
    end
    // Own flop so pin A0 also leaves a register
    s_d.pwmN = ~s_d.pwm;

    // Hardware set wins over a same-cycle write-one clear
    s_d.flags = (s_q.flags & ~w1c) | {wrap, match};
    // Wrap and compare-match requests each gated by its own enable
    s_d.irq = |(s_d.flags & s_d.ier[4:0]);

    s_d.oeA = ~s_d.outDis[rpwm_pkg::PIN_A0_BIT];
    s_d.oeB = ~s_d.outDis[rpwm_pkg::PIN_B0_BIT];
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_q <= '0;
      s_q.ctrl <= rpwm_pkg::CTRL_RESET;
      s_q.ier <= rpwm_pkg::IER_RESET;
      s_q.gra0 <= PeriodReset;
      s_q.grb0 <= ChangeReset;
      s_q.grc0 <= rpwm_pkg::GR_RESET;
      s_q.grd0 <= rpwm_pkg::GR_RESET;
      s_q.gra1 <= rpwm_pkg::GR_RESET;
      // Both pins released until software enables them
      s_q.outDis <= rpwm_pkg::OUTDIS_RESET;
      s_q.pwmN <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign awready = s_q.awready;
  assign wready = s_q.wready;
  assign bresp = s_q.bresp;
  assign bvalid = s_q.bvalid;
  assign arready = s_q.arready;
  assign rdata = s_q.rdata;
  assign rresp = s_q.rresp;
  assign rvalid = s_q.rvalid;
  assign clearOut = s_q.clearOut;
  // Pin A0 is the counter-phase of B0
  assign pwmPinA0Out = s_q.pwmN;
  assign pwmPinA0Oe = s_q.oeA;
  assign pwmPinB0Out = s_q.pwm;
  assign pwmPinB0Oe = s_q.oeB;
  assign irq = s_q.irq;

endmodule

// [tb/rpwm_channel0_monitor.sv]
// Port checker for rpwm_channel0: bus handshakes and PWM legs.
// Assumes a bind to the design top; one clock domain.
`timescale 1ns/1ps
module rpwm_channel0_monitor (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic pwmPinA0Out,
  input wire logic pwmPinA0Oe,
  input wire logic pwmPinB0Out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence wrTaken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence rdTaken;
    arvalid && arready;
  endsequence
  bresp_hold_a:
    assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  rdata_hold_a:
    assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  write_answer_a:
    assert property (wrTaken |-> ##[1:3] bvalid)
    else $error("no write response");
  read_answer_a:
    assert property (rdTaken |=> rvalid)
    else $error("no read data");
  wr_busy_a:
    assert property (bvalid |-> !awready && !wready)
    else $error("write ready while answering");
  rvalid_cause_a:
    assert property ($rose(rvalid) |-> $past(arvalid) && $past(arready))
    else $error("read data unasked");
  leg_phase_a:
    assert property (pwmPinA0Out != pwmPinB0Out)
    else $error("legs not complementary");
  oe_cause_a:
    assert property ($changed(pwmPinA0Oe) |-> ##[0:3] bvalid)
    else $error("pin enable moved unasked");
endmodule

bind rpwm_channel0 rpwm_channel0_monitor rpwm_channel0_monitor_i (
  .clk, .reset_n, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid,
  .bready, .arvalid, .arready, .rdata, .rvalid, .rready, .pwmPinA0Out,
  .pwmPinA0Oe, .pwmPinB0Out);

// [tb/rpwm_power_stage.sv]
// Power-stage model on the two channel-0 PWM legs.
// Assumes active-high gates; a released gate line floats.
`timescale 1ns/1ps
module rpwm_power_stage (
  input wire logic clk,
  input wire logic hiOut,
  input wire logic hiOe,
  input wire logic loOut,
  input wire logic loOe,
  output logic hiGate,
  output logic overlap
);
  logic flip = 1'b0;
  always @(posedge clk) flip <= !flip;
  assign hiGate = hiOe ? hiOut : flip;
  initial overlap = 1'b0;
  always @(posedge clk)
    if (hiOe && loOe && hiOut && loOut) overlap <= 1'b1;
endmodule

// [tb/rpwm_channel0_tb.sv]
// Self-checking bench for rpwm_channel0 with a power-stage model.
// Assumes a 25 MHz clock and an AXI4-Lite master in the tasks below.
`timescale 1ns/1ps
module rpwm_channel0_tb;
  localparam int Per = 20;
  typedef struct packed {
    logic [7:0] a;
    logic [31:0] rst;
    logic [31:0] w;
    logic [31:0] exp;
  } rpwm_row_t;
  logic clk, reset_n, awvalid, wvalid, bready, arvalid, rready;
  logic extIn = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, otherClear, clearOut;
  logic a0Out, a0Oe, b0Out, b0Oe, irq, gate, overlap;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  int mismatches, comparisons, cyc, n;
  logic [7:0] cfg [9] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25,
    8'h40, 8'hA0, 8'hC0};
  int gaps [9] = '{4, 8, 16, 32, 128, 32, 5, 6, 7};
  rpwm_row_t rows [9];
  rpwm_channel0 #(.PeriodCycles(Per)) rpwm_channel0_i (.clk, .reset_n,
    .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .externalCountInput(extIn), .otherClear, .clearOut,
    .pwmPinA0Out(a0Out), .pwmPinA0Oe(a0Oe), .pwmPinB0Out(b0Out),
    .pwmPinB0Oe(b0Oe), .irq);
  rpwm_power_stage rpwm_power_stage_i (.clk, .hiOut(b0Out), .hiOe(b0Oe),
    .loOut(a0Out), .loOe(a0Oe), .hiGate(gate), .overlap);
  initial begin
    clk = 1'b0;
    forever #20 clk = !clk;
  end
  // External count source: one rise every 8 cycles
  always begin
    repeat (4) @(posedge clk);
    extIn <= !extIn;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    if (mismatches == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Response ready is raised late on purpose to stall the slave
  task automatic busWr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid && !bready) bready <= 1'b1;
    end while (!(bvalid === 1'b1 && bready === 1'b1));
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic busRd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid && !rready) rready <= 1'b1;
    end while (!(rvalid === 1'b1 && rready === 1'b1));
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  task automatic pulses(input int c);
    n = 0;
    repeat (c) begin
      @(posedge clk);
      if (clearOut === 1'b1) n++;
    end
  endtask
  // First pulses after a change may be short, so skip two
  task automatic gap(input int exp);
    repeat (2) @(posedge clk iff (clearOut === 1'b1));
    pulses(0);
    do begin
      @(posedge clk);
      n++;
    end while (clearOut !== 1'b1 && n < 999);
    chk(32'(n), 32'(exp));
  endtask
  initial begin
    reset_n = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, otherClear} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    rows = '{
      '{8'h00, 32'h0000_0000, 32'h0000_00A5, 32'h0000_00A5},
      '{8'h04, 32'h0000_0000, 32'h0000_001F, 32'h0000_001F},
      '{8'h08, 32'(Per - 1), 32'hFFFF_FFFF, 32'h0000_FFFF},
      '{8'h0C, 32'h0000_04E2, 32'h0000_0000, 32'h0000_0000},
      '{8'h10, 32'h0000_FFFF, 32'h0000_0C7F, 32'h0000_0C7F},
      '{8'h14, 32'h0000_FFFF, 32'h0000_031F, 32'h0000_031F},
      '{8'h18, 32'h0000_FFFF, 32'h0000_063F, 32'h0000_063F},
      '{8'h20, 32'h0000_00FF, 32'h0000_005A, 32'h0000_005A},
      '{8'h30, 32'h0000_0000, 32'h1234_5678, 32'h0000_0000}};
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      busRd(rows[i].a);
      chk(rd, rows[i].rst);
      chk(32'(rs), 32'(i == 8 ? 2'h2 : 2'h0));
      busWr(rows[i].a, rows[i].w);
      chk(32'(rs), 32'(i == 8 ? 2'h2 : 2'h0));
      busRd(rows[i].a);
      chk(rd, rows[i].exp);
    end
    busWr(rpwm_pkg::OFS_GRA0, 32'h0000_0003);
    busWr(rpwm_pkg::OFS_GRB0, 32'h0000_0004);
    busWr(rpwm_pkg::OFS_GRC0, 32'h0000_0005);
    busWr(rpwm_pkg::OFS_GRD0, 32'h0000_0006);
    busWr(rpwm_pkg::OFS_RUN, 32'h0000_0001);
    for (int i = 0; i < 9; i++) begin
      busWr(rpwm_pkg::OFS_CTRL, 32'(cfg[i]));
      gap(gaps[i]);
    end
    busWr(rpwm_pkg::OFS_CTRL, 32'h0000_0026);
    pulses(50);
    chk(32'(n), 32'h0000_0000);
    busWr(rpwm_pkg::OFS_CTRL, 32'h0000_0080);
    pulses(30);
    chk(32'(n), 32'h0000_0000);
    busWr(rpwm_pkg::OFS_CTRL, 32'h0000_0060);
    pulses(100);
    chk(32'(n), 32'h0000_0000);
    otherClear <= 1'b1;
    @(posedge clk);
    otherClear <= 1'b0;
    pulses(4);
    chk(32'(n), 32'h0000_0001);
    busWr(rpwm_pkg::OFS_RUN, 32'h0000_0000);
    for (int v = 3; v >= 0; v--) begin
      busWr(rpwm_pkg::OFS_OUTDIS, 32'(v));
      repeat (2) @(posedge clk);
      chk(32'({a0Oe, b0Oe}), 32'({!v[0], !v[1]}));
    end
    busWr(rpwm_pkg::OFS_GRA0, 32'h0000_0028);
    busWr(rpwm_pkg::OFS_GRC0, 32'h0000_0009);
    busWr(rpwm_pkg::OFS_CTRL, 32'h0000_0020);
    busWr(rpwm_pkg::OFS_RUN, 32'h0000_0003);
    gap(10);
    busRd(rpwm_pkg::OFS_GRA0);
    chk(rd, 32'h0000_0009);
    @(posedge clk iff (clearOut === 1'b1));
    n = 0;
    repeat (10) begin
      if (gate === 1'b1) n++;
      @(posedge clk);
    end
    chk(32'(n), 32'h0000_0005);
    busWr(rpwm_pkg::OFS_RUN, 32'h0000_0000);
    busWr(rpwm_pkg::OFS_IER, 32'h0000_0000);
    busWr(rpwm_pkg::OFS_STATUS, 32'h0000_001F);
    busRd(rpwm_pkg::OFS_STATUS);
    chk(rd, 32'h0000_0000);
    busWr(rpwm_pkg::OFS_RUN, 32'h0000_0001);
    repeat (30) @(posedge clk);
    busRd(rpwm_pkg::OFS_STATUS);
    chk(rd, 32'h0000_000F);
    chk(32'(irq), 32'h0000_0000);
    for (int b = 0; b < 5; b++) begin
      busWr(rpwm_pkg::OFS_IER, 32'(1 << b));
      chk(32'(irq), 32'(b < 4));
    end
    busWr(rpwm_pkg::OFS_CTRL, 32'h0000_0000);
    n = 0;
    while (irq !== 1'b1 && n < 70000) begin
      @(posedge clk);
      n++;
    end
    chk(32'(irq), 32'h0000_0001);
    busRd(rpwm_pkg::OFS_STATUS);
    chk(rd & 32'h0000_0010, 32'h0000_0010);
    busWr(rpwm_pkg::OFS_RUN, 32'h0000_0000);
    busWr(rpwm_pkg::OFS_STATUS, 32'h0000_001F);
    chk(32'(irq), 32'h0000_0000);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    busRd(rpwm_pkg::OFS_OUTDIS);
    chk(rd, 32'h0000_00FF);
    chk(32'(overlap), 32'h0000_0000);
    tally_and_finish();
  end
endmodule
